// File: pkg/dls_pkg.sv
// Purpose: shared constants for the dual-port local sram block
// Assumes: 32-bit local bus, 64-Kbyte storage in two 32-Kbyte banks
// Notes:   config register fields and reset values live here
package dls_pkg;
  localparam int unsigned ADDR_W        = 32;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned BANK_AW       = 13;  // longword index inside one 32-Kbyte bank
  localparam int unsigned BANK_WORDS    = 8192;
  localparam int unsigned BANK_SEL_BIT  = 15;
  localparam int unsigned BASE_HI       = 31;
  localparam int unsigned BASE_LO       = 16;
  localparam int unsigned PRI_UPPER_BIT = 11;
  localparam int unsigned PRI_LOWER_BIT = 10;
  localparam int unsigned SPV_BIT       = 9;
  localparam int unsigned WP_BIT        = 8;
  localparam int unsigned MASK_HI       = 5;
  localparam int unsigned MASK_LO       = 1;
  localparam int unsigned VALID_BIT     = 0;
  // implemented bits: base, priority, port enable, write protect, masks, valid
  localparam logic [31:0] CFG_DEFINED   = 32'hffff_0f3f;
  localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
  // address space codes, one per mask bit
  localparam logic [2:0]  AS_CPU_SPACE  = 3'h0;
  localparam logic [2:0]  AS_SUP_CODE   = 3'h1;
  localparam logic [2:0]  AS_SUP_DATA   = 3'h2;
  localparam logic [2:0]  AS_USER_CODE  = 3'h3;
  localparam logic [2:0]  AS_USER_DATA  = 3'h4;
  localparam logic [1:0]  SIZE_BYTE     = 2'h0;
  localparam logic [1:0]  SIZE_WORD     = 2'h1;
  localparam logic [1:0]  SIZE_LONG     = 2'h2;
endpackage : dls_pkg

// File: hdl/dls_lanes.sv
// Purpose: byte-enable decode and write-data lane steering
// Assumes: big-endian byte order, byte 0 in bits 31:24
// Notes:   misaligned word or long is forced to its natural alignment
`timescale 1ns/1ps
module dls_lanes (
  input  wire logic [1:0]  size,
  input  wire logic [1:0]  addr_lo,
  input  wire logic [31:0] wdata_in,
  output logic      [3:0]  byte_en,
  output logic      [31:0] wdata_out
);
  always_comb begin
    byte_en   = 4'hf;
    wdata_out = wdata_in;
    unique case (size)
      dls_pkg::SIZE_BYTE: begin
        byte_en   = 4'h8 >> addr_lo;
        wdata_out = {4{wdata_in[7:0]}};
      end
      dls_pkg::SIZE_WORD: begin
        byte_en   = addr_lo[1] ? 4'h3 : 4'hc;
        wdata_out = {2{wdata_in[15:0]}};
      end
      default: begin
        byte_en   = 4'hf;
        wdata_out = wdata_in;
      end
    endcase
  end
endmodule : dls_lanes

// File: hdl/dls_bank.sv
// Purpose: one 32-Kbyte storage bank with per-byte write
// Assumes: one access per cycle, read data registered
// Notes:   contents undefined after reset
`timescale 1ns/1ps
module dls_bank (
  input  wire logic                         clk,
  input  wire logic                         en,
  input  wire logic                         we,
  input  wire logic [dls_pkg::BANK_AW-1:0]  addr,
  input  wire logic [3:0]                   byte_en,
  input  wire logic [31:0]                  wdata,
  output logic      [31:0]                  rdata
);
  logic [31:0] mem [dls_pkg::BANK_WORDS];

  for (genvar b = 0; b < 4; b++) begin : g_lane
    always_ff @(posedge clk) begin
      if (en && we && byte_en[b]) begin
        mem[addr][8*b +: 8] <= wdata[8*b +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (en) begin
      rdata <= mem[addr];
    end
  end
endmodule : dls_bank

// File: hdl/dls_sram.sv
// Purpose: 64-Kbyte local sram, cpu port, dma port, config register
// Assumes: requests held until ready; inputs synchronous to clk
// Notes:   cpu read data appears one cycle after the request is taken
`timescale 1ns/1ps

// How it works
// - a cpu access mapped here completes in one clock cycle, or two when dma wins a clash for the same bank
// - base sits on any 64-Kbyte boundary in the 32-bit space
// - cpu requests and debug memory commands share the local port
// - a fetch mapped here is answered here and the cache result dropped
// - data from this block is flagged never to be cached
// - two 32-Kbyte banks let cpu and dma work in parallel
// - the cpu may write the config register only with a privileged move
// - debug may read and write the config register
// - undefined config bits ignore writes and read as zero
// - reset clears only the valid bit
// - bits 31..16 hold the base; upper address bits must match
// - bit 11 upper, bit 10 lower bank priority; one means cpu wins
// - bit 9 enables the dma port; zero blocks dma
// - dma also needs the global dual-port enable from system control
// - bit 8 set makes the block read-only; writes raise access error
// - bit 0 clear disables the whole block
// - bits 5..1 mask five address spaces; masked access is not claimed
// - byte, word and long accesses write only the addressed bytes
module dls_sram (
  input  wire logic        clk,
  input  wire logic        reset,
  // cpu / debug local port
  input  wire logic        cpu_req,
  input  wire logic        cpu_we,
  input  wire logic [31:0] cpu_addr,
  input  wire logic [1:0]  cpu_size,
  input  wire logic [2:0]  cpu_space,
  input  wire logic [31:0] cpu_wdata,
  output logic             cpu_hit_r,
  output logic             cpu_ready_r,
  output logic             cpu_rvalid_r,
  output logic [31:0]      cpu_rdata_r,
  output logic             cpu_no_alloc_r,
  output logic             cache_discard_r,
  output logic             access_error_r,
  // config register writes and debug reads
  input  wire logic        cfg_wr,
  input  wire logic        cfg_wr_supervisor,
  input  wire logic        dbg_cfg_wr,
  input  wire logic        dbg_cfg_rd,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      dbg_cfg_rdata_r,
  output logic             dbg_cfg_rvalid_r,
  // dma port
  input  wire logic        dual_port_global_enable,
  input  wire logic        dma_req,
  input  wire logic        dma_we,
  input  wire logic [31:0] dma_addr,
  input  wire logic [1:0]  dma_size,
  input  wire logic [31:0] dma_wdata,
  output logic             dma_ready_r,
  output logic             dma_rvalid_r,
  output logic [31:0]      dma_rdata_r,
  output logic             dma_error_r
);
  // ****************************************************************
  // config register
  // ****************************************************************
  logic [31:0] sram_base_config_r;
  logic [31:0] cfg_nxt;

  always_comb begin
    cfg_nxt = sram_base_config_r;
    if (dbg_cfg_wr) begin
      cfg_nxt = cfg_wdata & dls_pkg::CFG_DEFINED;
    end else if (cfg_wr && cfg_wr_supervisor) begin
      cfg_nxt = cfg_wdata & dls_pkg::CFG_DEFINED;
    end
  end

  // only the valid bit has a reset term; the rest keep their value
  always_ff @(posedge clk) begin
    sram_base_config_r <= cfg_nxt;
    if (reset) begin
      sram_base_config_r[dls_pkg::VALID_BIT] <= 1'b0;
    end
  end

  // the cpu has no read path to the register; debug only
  always_ff @(posedge clk) begin
    if (reset) begin
      dbg_cfg_rdata_r  <= 32'h0000_0000;
      dbg_cfg_rvalid_r <= 1'b0;
    end else begin
      dbg_cfg_rvalid_r <= dbg_cfg_rd;
      if (dbg_cfg_rd) begin
        dbg_cfg_rdata_r <= sram_base_config_r & dls_pkg::CFG_DEFINED;
      end
    end
  end

  // ****************************************************************
  // field decode
  // ****************************************************************
  logic        cfg_valid;
  logic        wr_protect;
  logic        port2_on;
  logic [1:0]  bank_priority_select;
  logic [4:0]  address_space_masks;
  logic        space_masked;

  assign cfg_valid            = sram_base_config_r[dls_pkg::VALID_BIT];
  assign wr_protect           = sram_base_config_r[dls_pkg::WP_BIT];
  assign address_space_masks  = sram_base_config_r[dls_pkg::MASK_HI:dls_pkg::MASK_LO];
  // bit 0 of the pair is the lower bank, bit 1 the upper
  assign bank_priority_select = {sram_base_config_r[dls_pkg::PRI_UPPER_BIT],
                                 sram_base_config_r[dls_pkg::PRI_LOWER_BIT]};
  assign port2_on = sram_base_config_r[dls_pkg::SPV_BIT]
                    && dual_port_global_enable;

  // mask bit 5 is cpu space, bit 1 user data
  always_comb begin
    space_masked = 1'b0;
    unique case (cpu_space)
      dls_pkg::AS_CPU_SPACE: space_masked = address_space_masks[4];
      dls_pkg::AS_SUP_CODE:  space_masked = address_space_masks[3];
      dls_pkg::AS_SUP_DATA:  space_masked = address_space_masks[2];
      dls_pkg::AS_USER_CODE: space_masked = address_space_masks[1];
      dls_pkg::AS_USER_DATA: space_masked = address_space_masks[0];
      default:               space_masked = 1'b1;
    endcase
  end

  logic cpu_claim;
  logic dma_claim;

  assign cpu_claim = cpu_req && cfg_valid && !space_masked
                     && (cpu_addr[dls_pkg::BASE_HI:dls_pkg::BASE_LO]
                         == sram_base_config_r[dls_pkg::BASE_HI:dls_pkg::BASE_LO]);
  assign dma_claim = dma_req && cfg_valid
                     && (dma_addr[dls_pkg::BASE_HI:dls_pkg::BASE_LO]
                         == sram_base_config_r[dls_pkg::BASE_HI:dls_pkg::BASE_LO]);

  // ****************************************************************
  // arbitration
  // ****************************************************************
  logic cpu_bank;
  logic dma_bank;
  logic cpu_wp_err;
  logic dma_wp_err;
  logic clash;
  logic cpu_first;
  logic cpu_go;
  logic dma_go;

  assign cpu_bank   = cpu_addr[dls_pkg::BANK_SEL_BIT];
  assign dma_bank   = dma_addr[dls_pkg::BANK_SEL_BIT];
  assign cpu_wp_err = cpu_claim && cpu_we && wr_protect;
  assign dma_wp_err = dma_claim && port2_on && dma_we && wr_protect;
  assign clash      = cpu_claim && !cpu_wp_err && dma_claim && port2_on
                      && !dma_wp_err && (cpu_bank == dma_bank);
  assign cpu_first  = bank_priority_select[cpu_bank];
  assign cpu_go     = cpu_claim && !cpu_wp_err && !(clash && !cpu_first);
  assign dma_go     = dma_claim && port2_on && !dma_wp_err
                      && !(clash && cpu_first);

  // ****************************************************************
  // lane steering and banks
  // ****************************************************************
  logic [3:0]  cpu_be;
  logic [3:0]  dma_be;
  logic [31:0] cpu_wd;
  logic [31:0] dma_wd;

  dls_lanes u_cpu_lanes (
    .size      (cpu_size),
    .addr_lo   (cpu_addr[1:0]),
    .wdata_in  (cpu_wdata),
    .byte_en   (cpu_be),
    .wdata_out (cpu_wd)
  );

  dls_lanes u_dma_lanes (
    .size      (dma_size),
    .addr_lo   (dma_addr[1:0]),
    .wdata_in  (dma_wdata),
    .byte_en   (dma_be),
    .wdata_out (dma_wd)
  );

  logic [31:0] bank_rdata [2];
  logic        cpu_bank_r;
  logic        dma_bank_r;

  for (genvar k = 0; k < 2; k++) begin : g_bank
    logic                        use_cpu;
    logic                        b_en;
    logic                        b_we;
    logic [dls_pkg::BANK_AW-1:0] b_addr;
    logic [3:0]                  b_be;
    logic [31:0]                 b_wd;

    assign use_cpu = cpu_go && (cpu_bank == 1'(k));
    assign b_en    = use_cpu || (dma_go && (dma_bank == 1'(k)));
    assign b_we    = use_cpu ? cpu_we : dma_we;
    assign b_addr  = use_cpu ? cpu_addr[14:2] : dma_addr[14:2];
    assign b_be    = use_cpu ? cpu_be : dma_be;
    assign b_wd    = use_cpu ? cpu_wd : dma_wd;

    dls_bank u_bank (
      .clk     (clk),
      .en      (b_en),
      .we      (b_we),
      .addr    (b_addr),
      .byte_en (b_be),
      .wdata   (b_wd),
      .rdata   (bank_rdata[k])
    );
  end

  // ****************************************************************
  // cpu answer
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      cpu_hit_r       <= 1'b0;
      cpu_ready_r     <= 1'b0;
      cpu_rvalid_r    <= 1'b0;
      cpu_no_alloc_r  <= 1'b0;
      cache_discard_r <= 1'b0;
      access_error_r  <= 1'b0;
      cpu_bank_r      <= 1'b0;
    end else begin
      cpu_hit_r       <= cpu_claim;
      cpu_ready_r     <= cpu_go || cpu_wp_err;
      cpu_rvalid_r    <= cpu_go && !cpu_we;
      cpu_no_alloc_r  <= cpu_go && !cpu_we;
      cache_discard_r <= cpu_go && !cpu_we;
      access_error_r  <= cpu_wp_err;
      cpu_bank_r      <= cpu_bank;
    end
  end

  // read data follows the bank output of the cycle after the take
  always_comb begin
    cpu_rdata_r = bank_rdata[cpu_bank_r];
  end

  // ****************************************************************
  // dma answer
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      dma_ready_r  <= 1'b0;
      dma_rvalid_r <= 1'b0;
      dma_error_r  <= 1'b0;
      dma_bank_r   <= 1'b0;
    end else begin
      dma_ready_r  <= dma_go || dma_wp_err;
      dma_rvalid_r <= dma_go && !dma_we;
      dma_error_r  <= dma_wp_err;
      dma_bank_r   <= dma_bank;
    end
  end

  always_comb begin
    dma_rdata_r = bank_rdata[dma_bank_r];
  end
endmodule : dls_sram

// File: bench/dls_sram_checker.sv
// Purpose: port-level assertions for dls_sram
// Assumes: a config shadow follows every accepted write
// Notes:   bound to every dls_sram instance
`timescale 1ns/1ps
module dls_sram_checker (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        cpu_req,
  input wire logic        cpu_we,
  input wire logic [31:0] cpu_addr,
  input wire logic [2:0]  cpu_space,
  input wire logic        cpu_ready_r,
  input wire logic        cpu_no_alloc_r,
  input wire logic        cache_discard_r,
  input wire logic        access_error_r,
  input wire logic        cfg_wr,
  input wire logic        cfg_wr_supervisor,
  input wire logic        dbg_cfg_wr,
  input wire logic        dbg_cfg_rd,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] dbg_cfg_rdata_r,
  input wire logic        dual_port_global_enable,
  input wire logic        dma_req,
  input wire logic [31:0] dma_addr,
  input wire logic        dma_ready_r
);
  logic [31:0] cfg_r;
  // reset spares all but the valid bit, so the shadow does too
  always_ff @(posedge clk) begin
    if (reset) cfg_r[0] <= 1'h0;
    else if (dbg_cfg_wr || (cfg_wr && cfg_wr_supervisor)) cfg_r <= cfg_wdata;
  end
  wire logic cpu_ok = cfg_r[0] && cpu_addr[31:16] == cfg_r[31:16] && cpu_space < 3'h5
                      && !cfg_r[3'h5 - cpu_space];
  wire logic dma_ok = cfg_r[0] && cfg_r[9] && dual_port_global_enable
                      && dma_addr[31:16] == cfg_r[31:16];
  wire logic cpu_wins = cpu_addr[15] ? cfg_r[11] : cfg_r[10];
  // ****
  // assertions
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_clash; cpu_req && cpu_ok && dma_req && dma_ok && cpu_addr[15] == dma_addr[15]; endsequence
  sequence s_prot_wr; cpu_req && cpu_ok && cpu_we && cfg_r[8] && !dma_req; endsequence
  property p_single; cpu_req && cpu_ok && !dma_req |=> cpu_ready_r; endproperty
  a_single: assert property (p_single) else $error("cpu access late");
  property p_read; cpu_req && cpu_ok && !cpu_we && !dma_req |=> cpu_no_alloc_r && cache_discard_r; endproperty
  a_read: assert property (p_read) else $error("read flags missing");
  property p_base; cpu_req && cfg_r[0] && cpu_addr[31:16] != cfg_r[31:16] |=> !cpu_ready_r; endproperty
  a_base: assert property (p_base) else $error("foreign address claimed");
  property p_off; cpu_req && !cfg_r[0] |=> !cpu_ready_r; endproperty
  a_off: assert property (p_off) else $error("disabled block answered");
  property p_mask; cpu_req && cpu_space < 3'h5 && cfg_r[3'h5 - cpu_space] |=> !cpu_ready_r; endproperty
  a_mask: assert property (p_mask) else $error("masked space claimed");
  property p_prot; s_prot_wr |=> cpu_ready_r && access_error_r; endproperty
  a_prot: assert property (p_prot) else $error("protected write not refused");
  property p_dma_off; dma_req && !dma_ok |=> !dma_ready_r; endproperty
  a_dma_off: assert property (p_dma_off) else $error("dma served while off");
  property p_cfg_rd; dbg_cfg_rd && !dbg_cfg_wr && !cfg_wr |=> dbg_cfg_rdata_r == ($past(cfg_r) & 32'hffff_0f3f); endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");
  property p_pri; s_clash |=> cpu_ready_r != dma_ready_r && cpu_ready_r == $past(cpu_wins); endproperty
  a_pri: assert property (p_pri) else $error("bank clash order wrong");
endmodule : dls_sram_checker
bind dls_sram dls_sram_checker u_chk (.*);

// File: bench/dls_dma_master.sv
// Purpose: dma bus master model on the second port
// Assumes: ready shows on the falling edge after the take
// Notes:   released address and data are scrambled
`timescale 1ns/1ps
module dls_dma_master (
  input  wire logic        clk,
  input  wire logic        dma_ready_r,
  input  wire logic [31:0] dma_rdata_r,
  output logic             dma_req,
  output logic             dma_we,
  output logic [31:0]      dma_addr,
  output logic [1:0]       dma_size,
  output logic [31:0]      dma_wdata
);
  initial begin
    dma_req = 1'h0;
    dma_we = 1'h0;
    dma_addr = 32'h0;
    dma_size = 2'h2;
    dma_wdata = 32'h0;
  end
  // gap idle cycles let the same model start promptly or late
  task automatic access(input logic we, input logic [31:0] a, input logic [31:0] d,
                        input int gap, output logic [31:0] q, output int cyc);
    repeat (gap + 1) @(negedge clk);
    dma_we = we;
    dma_addr = a;
    dma_wdata = d;
    dma_req = 1'h1;
    cyc = 0;
    for (int i = 1; i <= 4 && cyc == 0; i++) begin
      @(negedge clk);
      cyc = (dma_ready_r === 1'h1) ? i : 0;
      q = dma_rdata_r;
    end
    dma_req = 1'h0;
    dma_addr = ~dma_addr;
    dma_wdata = ~dma_wdata;
  endtask : access
endmodule : dls_dma_master

// File: bench/dual_port_local_sram_bench.sv
// Purpose: directed bench for dls_sram
// Assumes: inputs change on falling edges
// Notes:   dma traffic comes from dls_dma_master
`timescale 1ns/1ps
module dual_port_local_sram_bench;
  localparam logic [31:0] BASE = 32'h2000_0000;
  logic        clk, reset, cpu_req, cpu_we, cfg_wr, cfg_wr_supervisor, dbg_cfg_wr, win;
  logic        dbg_cfg_rd, dual_port_global_enable, dma_req, dma_we;
  logic [1:0]  cpu_size, dma_size;
  logic [2:0]  cpu_space;
  logic [3:0]  fl;
  logic [31:0] cpu_addr, cpu_wdata, cfg_wdata, dma_addr, dma_wdata, q, dq;
  logic        cpu_hit_r, cpu_ready_r, cpu_rvalid_r, cpu_no_alloc_r, cache_discard_r;
  logic        access_error_r, dbg_cfg_rvalid_r, dma_ready_r, dma_rvalid_r, dma_error_r;
  logic [31:0] cpu_rdata_r, dbg_cfg_rdata_r, dma_rdata_r;
  int          n_mismatch, check_count, cyc, dcyc;
  dls_sram DUT (.*);
  dls_dma_master u_dma (.*);
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // exp is the cycle ready should show in, 0 for a refused request
  task automatic cpu_acc(input logic we, input logic [1:0] sz, input logic [2:0] sp,
                         input logic [31:0] a, input logic [31:0] d, input int exp);
    @(negedge clk);
    {cpu_we, cpu_size, cpu_space, cpu_addr, cpu_wdata, cpu_req} = {we, sz, sp, a, d, 1'h1};
    cyc = 0;
    for (int i = 1; i <= 4 && cyc == 0; i++) begin
      @(negedge clk);
      cyc = (cpu_ready_r === 1'h1) ? i : 0;
      q = cpu_rdata_r;
      fl = {access_error_r, cpu_no_alloc_r, cache_discard_r, cpu_rvalid_r};
    end
    {cpu_req, cpu_addr, cpu_wdata} = {1'h0, ~cpu_addr, ~cpu_wdata};
    check("cpu_cycles", cyc, exp);
    if (exp != 0 && cyc == 0) report_and_stop();
  endtask : cpu_acc
  task automatic cfg_put(input logic dbg, input logic sup, input logic [31:0] v);
    @(negedge clk);
    {dbg_cfg_wr, cfg_wr, cfg_wr_supervisor, cfg_wdata} = {dbg, ~dbg, sup, v};
    @(negedge clk);
    {dbg_cfg_wr, cfg_wr, cfg_wdata} = {2'h0, ~v};
  endtask : cfg_put
  task automatic cfg_get(input logic [31:0] exp);
    @(negedge clk);
    dbg_cfg_rd = 1'h1;
    @(negedge clk);
    dbg_cfg_rd = 1'h0;
    check("cfg_valid", dbg_cfg_rvalid_r, 1'h1);
    check("cfg_data", dbg_cfg_rdata_r, exp);
  endtask : cfg_get
  // ****
  // main sequence
  // ****
  initial begin
    {cpu_req, cpu_we, cfg_wr, cfg_wr_supervisor, dbg_cfg_wr, dbg_cfg_rd} = 6'h0;
    {cpu_size, cpu_space, cpu_addr, cpu_wdata, cfg_wdata} = 101'h0;
    dual_port_global_enable = 1'h1;
    n_mismatch = 0;
    check_count = 0;
    reset = 1'h1;
    repeat (12) @(negedge clk);
    reset = 1'h0;
    cfg_put(1'h1, 1'h0, 32'hffff_ffff);
    cfg_get(32'hffff_0f3f);
    cfg_put(1'h0, 1'h0, 32'h0);
    cfg_get(32'hffff_0f3f);
    cfg_put(1'h0, 1'h1, BASE | 32'h1);
    cfg_get(BASE | 32'h1);
    $display("test config done");
    cpu_acc(1'h1, 2'h2, 3'h2, BASE, 32'h1122_3344, 1);
    cpu_acc(1'h1, 2'h0, 3'h2, BASE + 32'h1, 32'haa, 1);
    cpu_acc(1'h1, 2'h1, 3'h2, BASE + 32'h2, 32'hbeef, 1);
    cpu_acc(1'h0, 2'h2, 3'h1, BASE, 32'h0, 1);
    check("lanes", q, 32'h11aa_beef);
    check("fetch_flags", fl, 4'h7);
    cfg_put(1'h1, 1'h0, 32'hfedc_0001);
    cpu_acc(1'h0, 2'h2, 3'h2, BASE, 32'h0, 0);
    cpu_acc(1'h0, 2'h2, 3'h2, 32'hfedc_0000, 32'h0, 1);
    check("moved", q, 32'h11aa_beef);
    $display("test memory done");
    for (int s = 0; s < 5; s++) begin
      cfg_put(1'h1, 1'h0, BASE | 32'h1 | (32'h20 >> s));
      cpu_acc(1'h0, 2'h2, 3'(s), BASE, 32'h0, 0);
      cpu_acc(1'h0, 2'h2, 3'((s + 1) % 5), BASE, 32'h0, 1);
    end
    $display("test masks done");
    u_dma.access(1'h0, BASE, 32'h0, 0, dq, dcyc);
    check("dma_off", dcyc, 0);
    cfg_put(1'h1, 1'h0, BASE | 32'h201);
    dual_port_global_enable = 1'h0;
    u_dma.access(1'h0, BASE, 32'h0, 0, dq, dcyc);
    check("dma_global", dcyc, 0);
    dual_port_global_enable = 1'h1;
    u_dma.access(1'h1, BASE + 32'h8000, 32'h6677_8899, 3, dq, dcyc);
    for (int p = 0; p < 9; p++) begin
      cfg_put(1'h1, 1'h0, BASE | 32'h201 | (32'(p / 2 % 4) << 10));
      win = (p == 8) || (p % 2 == 1 ? p / 4 % 2 == 1 : p / 2 % 2 == 1);
      fork
        cpu_acc(1'h0, 2'h2, 3'h2, BASE + (32'(p % 2) << 15), 32'h0, win ? 1 : 2);
        u_dma.access(1'h0, BASE + (32'((p % 2) ^ (p / 8)) << 15), 32'h0, 0, dq, dcyc);
      join
      check("dma_turn", dcyc, (win && p < 8) ? 2 : 1);
      check("bank_data", q, (p % 2 == 1) ? 32'h6677_8899 : 32'h11aa_beef);
      check("dma_data", dq, (((p % 2) ^ (p / 8)) == 1) ? 32'h6677_8899 : 32'h11aa_beef);
    end
    $display("test dma done");
    reset = 1'h1;
    repeat (2) @(negedge clk);
    reset = 1'h0;
    cfg_get(BASE | 32'h200);
    cpu_acc(1'h0, 2'h2, 3'h2, BASE, 32'h0, 0);
    cfg_put(1'h1, 1'h0, BASE | 32'h101);
    cpu_acc(1'h1, 2'h2, 3'h2, BASE, 32'h5555_5555, 1);
    check("wp_error", fl[3], 1'h1);
    cpu_acc(1'h0, 2'h2, 3'h2, BASE, 32'h0, 1);
    check("wp_kept", q, 32'h11aa_beef);
    $display("test reset and protect done");
    report_and_stop();
  end
endmodule : dual_port_local_sram_bench
